//--- logic/tvsf_map.svh
`ifndef TVSF_MAP_SVH
`define TVSF_MAP_SVH
`define TVSF_CLK_MHZ 250
`define TVSF_US_PER_MS 1000
`define TVSF_FRAME_US 37040
`define TVSF_SYNC_TO_MS 185
`define TVSF_LINE_US 500
`define TVSF_PKT_TO_LINES 3
`define TVSF_B_ID_HI 8'd0
`define TVSF_B_ID_LO 8'd1
`define TVSF_B_CRC_HI 8'd2
`define TVSF_B_CRC_LO 8'd3
`define TVSF_HDR_BYTES 8'd4
`define TVSF_PAY_RAW 8'd160
`define TVSF_PAY_RGB 8'd240
`define TVSF_ROWS 12'd60
`define TVSF_PKTS_TEL 12'd63
`define TVSF_TEL_LINES 12'd3
`define TVSF_LINE_PIX 7'd80
`define TVSF_ID_NUM_MASK 16'h0fff
`define TVSF_DISCARD_ID 16'h0f00
`define TVSF_CRC_POLY 16'h1021
`define TVSF_CRC_INIT 16'h0000
`define TVSF_RAW_MASK 16'h3fff
`define TVSF_AGC_MASK 16'h00ff
`define TVSF_FCNT_STEP 32'd3
`define TVSF_DUP_LAST 2'd2
`define TVSF_FCNT_COL_HI 7'd0
`define TVSF_FCNT_COL_LO 7'd1
`define TVSF_BIT_LAST 3'd7
`define TVSF_RGB_LAST_SUB 2'd2
`define TVSF_RAW_LAST_SUB 2'd1
`endif

//--- logic/tvsf_pkg.sv
package tvsf_pkg;

  typedef enum logic [1:0] {LINK_READY, LINK_SYNCED, LINK_LOST} tvsf_link_t;

  typedef enum logic [1:0] {PREP_IDLE, PREP_ID, PREP_ZERO, PREP_PIX} tvsf_prep_t;

  typedef struct packed {
    logic three_byte_colour_format;
    logic telemetry_en;
    logic telemetry_footer;
    logic automatic_gain_control;
    logic linear_temperature_output;
  } tvsf_cfg_t;

  typedef struct packed {
    logic tel;
    logic [5:0] line;
    logic [6:0] col;
  } tvsf_pix_req_t;

endpackage

//--- logic/tvsf_crc16.sv
`timescale 1ns/1ps
`default_nettype none
`include "tvsf_map.svh"
module tvsf_crc16 (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic clr,
  input wire logic en,
  input wire logic nb3,
  input wire logic [23:0] data,
  output logic [15:0] crc
);

  logic [15:0] crc_q;
  logic [15:0] crc_d;

  // Two or three bytes per cycle, most significant byte first, as they go on the wire.
  always_comb begin
    logic fb;
    fb = 1'b0;
    crc_d = crc_q;
    for (int i = 23; i >= 0; i--) begin
      if (i < 16 || nb3) begin
        fb = crc_d[15] ^ data[i];
        crc_d = {crc_d[14:0], 1'b0} ^ (fb ? `TVSF_CRC_POLY : 16'h0000);
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      crc_q <= `TVSF_CRC_INIT;
    end else if (ce) begin
      if (clr) begin
        crc_q <= `TVSF_CRC_INIT;
      end else if (en) begin
        crc_q <= crc_d;
      end
    end
  end

  assign crc = crc_q;

endmodule
`default_nettype wire

//--- logic/tvsf_framer.sv
`timescale 1ns/1ps
`default_nettype none
`include "tvsf_map.svh"
// Behaviour
// - Packet is four header bytes plus payload.
// - Raw format: 164 bytes, 60 or 63 packets.
// - Colour format: 244 bytes, 60 packets, no telemetry.
// - Header is ID word then CRC word.
// - Packet numbers restart at zero each frame.
// - CRC polynomial x16 + x12 + x5 + 1.
// - CRC spans packet, reserved and CRC zeroed.
// - Discard packets until synced and between frames.
// - Discard ID has nibble F, full payload.
// - Raw payload: 80 two-byte pixels in order.
// - Gain control off: top two bits zero, except with linear temperature output (full 16 bits).
// - Gain control on: top eight bits zero.
// - Colour payload: red, green, blue per pixel.
// - Telemetry lines placed as header or footer.
// - Frames near 27 Hz, two duplicates each.
// - Frame counter advances on unique frames only.
// - Long idle deselect resets to ready state.
// - Select after timeout starts a packet at once.
// - Video follows at next frame after first packet.
// - Mode 3, change on falling edge, MSB first.
// - Packet unfinished within three lines loses sync.
module tvsf_framer
  import tvsf_pkg::*;
#(
  parameter logic [31:0] FRAME_CYC = 32'(`TVSF_FRAME_US * `TVSF_CLK_MHZ),
  parameter logic [31:0] SYNC_TO_CYC = 32'(`TVSF_SYNC_TO_MS * `TVSF_US_PER_MS * `TVSF_CLK_MHZ),
  parameter logic [31:0] PKT_TO_CYC = 32'(`TVSF_PKT_TO_LINES * `TVSF_LINE_US * `TVSF_CLK_MHZ)
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire tvsf_cfg_t cfg,
  output tvsf_pix_req_t pix_req,
  output logic pix_rd,
  input wire logic [23:0] pix_data,
  output logic frame_strobe,
  output logic frame_unique,
  output logic [31:0] frame_count,
  output logic link_synced,
  output logic link_lost
);

  logic [1:0] pin_in;
  logic sck_s;
  logic cs_n_s;
  logic sck_prev_q;
  logic fall;
  logic rise;

  assign pin_in = {spi_cs_n, spi_sck};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      logic meta_q;
      logic sync_q;
      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          meta_q <= 1'b1;
          sync_q <= 1'b1;
        end else if (ce) begin
          meta_q <= pin_in[g];
          sync_q <= meta_q;
        end
      end
    end
  endgenerate

  assign sck_s = g_sync[0].sync_q;
  assign cs_n_s = g_sync[1].sync_q;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sck_prev_q <= 1'b1;
    end else if (ce) begin
      sck_prev_q <= sck_s;
    end
  end

  assign fall = ~cs_n_s & sck_prev_q & ~sck_s;
  assign rise = ~cs_n_s & ~sck_prev_q & sck_s;

  // Frame pacing and duplicate counting.
  logic [31:0] frm_cnt_q;
  logic [1:0] dup_q;
  logic [31:0] fcnt_q;
  logic fcnt_run_q;
  logic frame_evt;
  logic unique_evt;
  logic strobe_q;
  logic unique_q;

  assign frame_evt = (frm_cnt_q == FRAME_CYC - 32'd1);
  assign unique_evt = frame_evt && (dup_q == 2'd0);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      frm_cnt_q <= 32'h0000_0000;
      dup_q <= 2'd0;
      strobe_q <= 1'b0;
      unique_q <= 1'b0;
    end else if (ce) begin
      frm_cnt_q <= frame_evt ? 32'h0000_0000 : frm_cnt_q + 32'd1;
      if (frame_evt) begin
        dup_q <= (dup_q == `TVSF_DUP_LAST) ? 2'd0 : dup_q + 2'd1;
      end
      strobe_q <= frame_evt;
      unique_q <= unique_evt;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      fcnt_q <= 32'h0000_0000;
      fcnt_run_q <= 1'b0;
    end else if (ce && unique_evt) begin
      fcnt_run_q <= 1'b1;
      if (fcnt_run_q) begin
        fcnt_q <= fcnt_q + `TVSF_FCNT_STEP;
      end
    end
  end

  // Interface timeout and intra-packet timeout.
  logic [31:0] to_cnt_q;
  logic [31:0] pkt_tmr_q;
  logic link_idle;
  logic timeout_evt;
  logic pkt_to_evt;
  logic busy_q;
  logic prep_go_q;

  assign link_idle = cs_n_s & sck_s;
  assign timeout_evt = link_idle && (to_cnt_q == SYNC_TO_CYC - 32'd1);
  assign pkt_to_evt = busy_q && (pkt_tmr_q == PKT_TO_CYC - 32'd1);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      to_cnt_q <= 32'h0000_0000;
    end else if (ce) begin
      if (!link_idle) begin
        to_cnt_q <= 32'h0000_0000;
      end else if (to_cnt_q != SYNC_TO_CYC) begin
        to_cnt_q <= to_cnt_q + 32'd1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pkt_tmr_q <= 32'h0000_0000;
    end else if (ce) begin
      if (prep_go_q || !busy_q) begin
        pkt_tmr_q <= 32'h0000_0000;
      end else if (pkt_tmr_q != PKT_TO_CYC) begin
        pkt_tmr_q <= pkt_tmr_q + 32'd1;
      end
    end
  end

  // Link state and packet sequencing.
  tvsf_link_t st_q;
  tvsf_cfg_t cfg_q;
  logic seen_q;
  logic in_frame_q;
  logic pend_q;
  logic is_vid_q;
  logic [11:0] pkt_q;
  logic [11:0] npkts;
  logic video_now;
  logic pkt_done;
  logic frame_end;
  logic frame_busy;

  assign npkts = (cfg_q.telemetry_en && !cfg_q.three_byte_colour_format) ? `TVSF_PKTS_TEL : `TVSF_ROWS;
  // video only when synced with a frame
  assign video_now = (st_q == LINK_SYNCED) && (in_frame_q || pend_q);
  assign frame_end = pkt_done && is_vid_q && (pkt_q == npkts - 12'd1);
  assign frame_busy = (in_frame_q && !frame_end) || pend_q;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= LINK_READY;
      seen_q <= 1'b0;
      in_frame_q <= 1'b0;
      pend_q <= 1'b0;
      pkt_q <= 12'h000;
    end else if (ce) begin
      if (timeout_evt) begin
        st_q <= LINK_READY;
        seen_q <= 1'b0;
        in_frame_q <= 1'b0;
        pend_q <= 1'b0;
        pkt_q <= 12'h000;
      end else begin
        if (prep_go_q && video_now && pend_q) begin
          pend_q <= 1'b0;
          in_frame_q <= 1'b1;
        end
        if (pkt_done && st_q == LINK_READY) begin
          seen_q <= 1'b1;
        end
        if (frame_end) begin
          pkt_q <= 12'h000;
          in_frame_q <= 1'b0;
        end else if (pkt_done && is_vid_q) begin
          pkt_q <= pkt_q + 12'd1;
        end
        if ((pkt_to_evt || (frame_evt && frame_busy)) && st_q == LINK_SYNCED) begin
          st_q <= LINK_LOST;
          in_frame_q <= 1'b0;
          pend_q <= 1'b0;
          pkt_q <= 12'h000;
        end else if (frame_evt) begin
          case (st_q)
            LINK_READY: begin
              if (seen_q) begin
                st_q <= LINK_SYNCED;
                pend_q <= 1'b1;
              end
            end
            LINK_SYNCED: begin
              pend_q <= 1'b1;
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // Line selection for the next packet.
  logic sel_tel;
  logic [5:0] sel_line;
  logic tel_on;

  assign tel_on = cfg.telemetry_en && !cfg.three_byte_colour_format;

  always_comb begin
    sel_tel = 1'b0;
    sel_line = pkt_q[5:0];
    if (tel_on && cfg.telemetry_footer && pkt_q >= `TVSF_ROWS) begin
      sel_tel = 1'b1;
      sel_line = 6'(pkt_q - `TVSF_ROWS);
    end else if (tel_on && !cfg.telemetry_footer) begin
      if (pkt_q < `TVSF_TEL_LINES) begin
        sel_tel = 1'b1;
      end else begin
        sel_line = 6'(pkt_q - `TVSF_TEL_LINES);
      end
    end
  end

  // Packet preparation: the whole payload is fetched and folded into the CRC
  // before the CRC bytes are due, so the header can lead the payload.
  tvsf_prep_t prep_q;
  tvsf_pix_req_t req_q;
  logic [15:0] id_q;
  logic rd_q;
  logic rd_v_q;
  logic wr_v_q;
  logic [6:0] wr_col_q;
  logic boot_q;
  logic [23:0] pix_word;
  logic [23:0] crc_data;
  logic crc_en;
  logic [15:0] crc;
  logic [23:0] line_mem [0:79];

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      boot_q <= 1'b1;
      prep_go_q <= 1'b0;
    end else if (ce) begin
      boot_q <= 1'b0;
      // next packet is readied at once
      prep_go_q <= pkt_done || timeout_evt || boot_q;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      prep_q <= PREP_IDLE;
      cfg_q <= '0;
      is_vid_q <= 1'b0;
      id_q <= `TVSF_DISCARD_ID;
      req_q <= '0;
    end else if (ce) begin
      if (prep_go_q) begin
        cfg_q <= cfg;
        is_vid_q <= video_now;
        id_q <= video_now ? {4'h0, pkt_q} : `TVSF_DISCARD_ID;
        req_q <= '{tel: sel_tel, line: sel_line, col: 7'd0};
        prep_q <= PREP_ID;
      end else begin
        case (prep_q)
          PREP_ID: prep_q <= PREP_ZERO;
          PREP_ZERO: prep_q <= PREP_PIX;
          PREP_PIX: begin
            if (req_q.col == `TVSF_LINE_PIX - 7'd1) begin
              prep_q <= PREP_IDLE;
            end else begin
              req_q.col <= req_q.col + 7'd1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rd_q <= 1'b0;
      rd_v_q <= 1'b0;
      wr_v_q <= 1'b0;
      wr_col_q <= 7'd0;
    end else if (ce) begin
      rd_q <= (prep_q == PREP_PIX) && is_vid_q && !prep_go_q;
      rd_v_q <= (prep_q == PREP_PIX) && !prep_go_q;
      wr_v_q <= rd_v_q;
      wr_col_q <= pix_req.col;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pix_req <= '0;
    end else if (ce) begin
      pix_req <= req_q;
    end
  end

  always_comb begin
    pix_word = 24'h00_0000;
    if (is_vid_q) begin
      if (cfg_q.three_byte_colour_format) begin
        pix_word = pix_data;
      end else if (pix_req.tel) begin
        pix_word = {8'h00, pix_data[15:0]};
        // counter carried in first telemetry line
        if (pix_req.line == 6'd0 && wr_col_q == `TVSF_FCNT_COL_HI) begin
          pix_word = {8'h00, fcnt_q[31:16]};
        end else if (pix_req.line == 6'd0 && wr_col_q == `TVSF_FCNT_COL_LO) begin
          pix_word = {8'h00, fcnt_q[15:0]};
        end
      end else if (cfg_q.automatic_gain_control) begin
        // gain control narrows to eight bits
        pix_word = {8'h00, pix_data[15:0] & `TVSF_AGC_MASK};
      end else if (cfg_q.linear_temperature_output) begin
        pix_word = {8'h00, pix_data[15:0]};
      end else begin
        pix_word = {8'h00, pix_data[15:0] & `TVSF_RAW_MASK};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (ce && wr_v_q) begin
      line_mem[wr_col_q] <= pix_word;
    end
  end

  // reserved ID bits and CRC field enter as zero
  always_comb begin
    crc_data = 24'h00_0000;
    if (prep_q == PREP_ID) begin
      crc_data = {8'h00, id_q & `TVSF_ID_NUM_MASK};
    end else if (wr_v_q) begin
      crc_data = pix_word;
    end
  end

  assign crc_en = (prep_q == PREP_ID) || (prep_q == PREP_ZERO) || wr_v_q;

  tvsf_crc16 u_crc (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ce(ce),
    .clr(prep_go_q),
    .en(crc_en),
    .nb3(wr_v_q && cfg_q.three_byte_colour_format),
    .data(crc_data),
    .crc(crc)
  );

  // Serial side: bytes are fetched at the falling edge that starts them.
  logic [2:0] bit_q;
  logic [7:0] byte_q;
  logic [7:0] sh_q;
  logic miso_q;
  logic [6:0] pay_pix_q;
  logic [1:0] pay_sub_q;
  logic [7:0] last_byte;
  logic [1:0] last_sub;
  logic [23:0] pay_word;
  logic [7:0] byte_val;

  assign last_byte = `TVSF_HDR_BYTES - 8'd1 + (cfg_q.three_byte_colour_format ? `TVSF_PAY_RGB : `TVSF_PAY_RAW);
  assign last_sub = cfg_q.three_byte_colour_format ? `TVSF_RGB_LAST_SUB : `TVSF_RAW_LAST_SUB;
  assign pkt_done = rise && (bit_q == `TVSF_BIT_LAST) && (byte_q == last_byte);
  assign pay_word = line_mem[pay_pix_q];

  always_comb begin
    byte_val = 8'h00;
    if (byte_q == `TVSF_B_ID_HI) begin
      byte_val = id_q[15:8];
    end else if (byte_q == `TVSF_B_ID_LO) begin
      byte_val = id_q[7:0];
    end else if (byte_q == `TVSF_B_CRC_HI) begin
      byte_val = crc[15:8];
    end else if (byte_q == `TVSF_B_CRC_LO) begin
      byte_val = crc[7:0];
    end else if (cfg_q.three_byte_colour_format) begin
      byte_val = (pay_sub_q == 2'd0) ? pay_word[23:16] : (pay_sub_q == 2'd1) ? pay_word[15:8] : pay_word[7:0];
    end else begin
      byte_val = (pay_sub_q == 2'd0) ? pay_word[15:8] : pay_word[7:0];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      bit_q <= 3'd0;
      byte_q <= 8'd0;
      sh_q <= 8'h00;
      miso_q <= 1'b0;
      busy_q <= 1'b0;
      pay_pix_q <= 7'd0;
      pay_sub_q <= 2'd0;
    end else if (ce) begin
      if (timeout_evt) begin
        bit_q <= 3'd0;
        byte_q <= 8'd0;
        busy_q <= 1'b0;
        pay_pix_q <= 7'd0;
        pay_sub_q <= 2'd0;
      end else if (fall) begin
        busy_q <= 1'b1;
        if (bit_q == 3'd0) begin
          miso_q <= byte_val[7];
          sh_q <= {byte_val[6:0], 1'b0};
          if (byte_q >= `TVSF_HDR_BYTES) begin
            pay_sub_q <= (pay_sub_q == last_sub) ? 2'd0 : pay_sub_q + 2'd1;
            if (pay_sub_q == last_sub) begin
              pay_pix_q <= pay_pix_q + 7'd1;
            end
          end
        end else begin
          miso_q <= sh_q[7];
          sh_q <= {sh_q[6:0], 1'b0};
        end
      end else if (rise) begin
        // position advances on host clock only
        bit_q <= bit_q + 3'd1;
        if (pkt_done) begin
          byte_q <= 8'd0;
          busy_q <= 1'b0;
          pay_pix_q <= 7'd0;
          pay_sub_q <= 2'd0;
        end else if (bit_q == `TVSF_BIT_LAST) begin
          byte_q <= byte_q + 8'd1;
        end
      end
    end
  end

  assign spi_miso_oe = ~cs_n_s;
  assign spi_miso = miso_q;
  assign pix_rd = rd_q;
  assign frame_strobe = strobe_q;
  assign frame_unique = unique_q;
  assign frame_count = fcnt_q;
  assign link_synced = (st_q == LINK_SYNCED);
  assign link_lost = (st_q == LINK_LOST);

endmodule
`default_nettype wire

//--- test/tvsf_framer_checker.sv
`timescale 1ns/1ps
`default_nettype none
module tvsf_framer_checker
  import tvsf_pkg::*;
#(
  parameter logic [31:0] FRAME_CYC = 32'd9260000,
  parameter logic [31:0] SYNC_TO_CYC = 32'd46250000,
  parameter logic [31:0] PKT_TO_CYC = 32'd375000
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_miso,
  input wire logic spi_miso_oe,
  input wire tvsf_cfg_t cfg,
  input wire tvsf_pix_req_t pix_req,
  input wire logic pix_rd,
  input wire logic frame_strobe,
  input wire logic frame_unique,
  input wire logic [31:0] frame_count,
  input wire logic link_synced,
  input wire logic link_lost
);
  logic [6:0] run_q;
  logic [31:0] gap_q;
  logic [31:0] idle_q;
  logic [1:0] ph_q;
  logic seen_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // The idle count watches the pins, so the bound below leaves room for the synchroniser lag.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      run_q <= 7'h00;
      gap_q <= 32'h0;
      idle_q <= 32'h0;
      ph_q <= 2'h0;
      seen_q <= 1'b0;
    end else begin
      run_q <= pix_rd ? run_q + 7'h01 : 7'h00;
      gap_q <= frame_strobe ? 32'h0 : gap_q + 32'h1;
      idle_q <= (spi_cs_n && spi_sck) ? idle_q + 32'h1 : 32'h0;
      ph_q <= !frame_strobe ? ph_q : (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
      seen_q <= seen_q | frame_strobe;
    end
  end
  sequence sck_high4;
    (spi_sck && spi_miso_oe) [*4];
  endsequence
  sequence rd_start;
    !pix_rd ##1 pix_rd;
  endsequence
  oe_tracks_cs_a: assert property (spi_miso_oe == !$past(spi_cs_n, 2)) else $error("enable not tracking select");
  miso_held_a: assert property (sck_high4 |-> $stable(spi_miso)) else $error("data moved with clock high");
  burst_len_a: assert property ($fell(pix_rd) |-> run_q == 7'h50) else $error("line read not 80 words");
  col_first_a: assert property (rd_start |-> pix_req.col == 7'h00) else $error("line read not from pixel 0");
  col_step_a: assert property (pix_rd && $past(pix_rd) |-> pix_req.col == $past(pix_req.col) + 7'h01)
    else $error("pixel order broken");
  rows_only_a: assert property (pix_rd && !cfg.telemetry_en |-> !pix_req.tel && pix_req.line < 6'h3c)
    else $error("telemetry or bad row read");
  frame_period_a: assert property (frame_strobe && seen_q |-> gap_q == FRAME_CYC - 32'h1)
    else $error("frame period wrong");
  unique_third_a: assert property (frame_strobe |-> frame_unique == (ph_q == 2'h0))
    else $error("unique frame not every third");
  unique_strobe_a: assert property (frame_unique |-> frame_strobe) else $error("unique pulse outside frame");
  count_step_a: assert property ($changed(frame_count) |-> frame_count == $past(frame_count) + 32'h3)
    else $error("frame counter step wrong");
  idle_ready_a: assert property (idle_q == SYNC_TO_CYC + 32'h8 |-> !link_synced && !link_lost)
    else $error("idle timeout ignored");
  one_state_a: assert property (!(link_synced && link_lost)) else $error("synced and lost together");
  sync_on_frame_a: assert property ($rose(link_synced) |-> frame_strobe) else $error("sync outside frame event");
endmodule
bind tvsf_framer tvsf_framer_checker #(.FRAME_CYC(FRAME_CYC), .SYNC_TO_CYC(SYNC_TO_CYC), .PKT_TO_CYC(PKT_TO_CYC))
  u_tvsf_framer_checker (.clk_sys, .sys_rst, .spi_sck, .spi_cs_n, .spi_miso, .spi_miso_oe, .cfg, .pix_req,
  .pix_rd, .frame_strobe, .frame_unique, .frame_count, .link_synced, .link_lost);
`default_nettype wire

//--- test/tvsf_host.sv
`timescale 1ns/1ps
`default_nettype none
module tvsf_host (
  output var logic spi_sck,
  output var logic spi_cs_n,
  input wire logic spi_miso,
  input wire logic spi_miso_oe
);
  logic [7:0] rx_byte;
  logic last_q;
  event got;
  initial begin
    spi_sck = 1'b1;
    spi_cs_n = 1'b1;
    last_q = 1'b0;
    rx_byte = 8'h00;
  end
  // Mode 3 whole packets.
  // Clock is 31.25 MHz here against the 20 MHz ceiling; the design samples it with margin.
  // Pin moves land on clock edges, so they are scheduled after the edge samples them:
  // the design then sees each move one clock late, as a slow synchroniser would.
  task automatic rd(input int n);
    logic b;
    spi_cs_n <= 1'b0;
    repeat (n) begin
      for (int i = 0; i < 8; i++) begin
        #16 spi_sck <= 1'b0;
        #16 spi_sck <= 1'b1;
        b = spi_miso_oe ? spi_miso : !last_q;
        last_q = b;
        rx_byte = {rx_byte[6:0], b};
      end
      -> got;
    end
  endtask
  task automatic idle(input int ns);
    spi_cs_n <= 1'b1;
    #(ns);
  endtask
endmodule
`default_nettype wire

//--- test/tvsf_framer_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; $display("ERROR %0t: mismatch", $time); end end
module tvsf_framer_bench
  import tvsf_pkg::*;
;
  logic clk_sys, sys_rst, ce, pix_rd, frame_strobe, frame_unique, link_synced, link_lost, spi_miso, spi_miso_oe;
  wire spi_sck;
  wire spi_cs_n;
  tvsf_cfg_t cfg;
  tvsf_pix_req_t pix_req;
  logic [23:0] pix_data;
  logic [31:0] frame_count;
  logic [7:0] e [0:243];
  logic [7:0] exp_q [$];
  logic [7:0] exp_b;
  int miscompares, checks, uniq;
  tvsf_framer #(.FRAME_CYC(32'd16000), .SYNC_TO_CYC(32'd2000), .PKT_TO_CYC(32'd20000)) u_tvsf_framer (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .cfg(cfg), .pix_req(pix_req), .pix_rd(pix_rd), .pix_data(pix_data),
    .frame_strobe(frame_strobe), .frame_unique(frame_unique), .frame_count(frame_count),
    .link_synced(link_synced), .link_lost(link_lost));
  tvsf_host u_tvsf_host (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Pixel words are pseudo-random per address, so a misplaced pixel cannot match by chance.
  function automatic logic [23:0] px(input logic [13:0] a);
    logic [15:0] r1;
    logic [15:0] r2;
    r1 = lfsr(lfsr(16'hd1b4 ^ {2'h0, a}));
    r2 = lfsr(lfsr(r1));
    return {r2[7:0], r1};
  endfunction
  function automatic logic [15:0] crc_of(input int n);
    logic [15:0] c;
    logic [7:0] d;
    c = 16'h0000;
    for (int i = 0; i < n; i++) begin
      d = (i == 0) ? (e[0] & 8'h0f) : (i == 2 || i == 3) ? 8'h00 : e[i];
      for (int k = 7; k >= 0; k--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[k]) ? 16'h1021 : 16'h0000);
    end
    return c;
  endfunction
  // Kind 0 discard, 1 raw, 2 raw with gain control, 3 colour.
  task automatic expect_pkt(input int kind, input int num, input int n);
    logic [23:0] p;
    logic [15:0] c;
    e[0] = (kind == 0) ? 8'h0f : {4'h0, 4'(num >> 8)};
    e[1] = (kind == 0) ? 8'h00 : 8'(num);
    for (int i = 4; i < n; i++) e[i] = 8'h00;
    for (int col = 0; col < 80 && kind != 0; col++) begin
      p = px({1'b0, 6'(num), 7'(col)});
      if (kind == 3) {e[4 + 3 * col], e[5 + 3 * col], e[6 + 3 * col]} = p;
      else {e[4 + 2 * col], e[5 + 2 * col]} = p[15:0] & ((kind == 2) ? 16'h00ff : 16'h3fff);
    end
    c = crc_of(n);
    e[2] = c[15:8];
    e[3] = c[7:0];
    for (int i = 0; i < n; i++) exp_q.push_back(e[i]);
    u_tvsf_host.rd(n);
  endtask
  task automatic finish_test;
    $display("miscompares=%0d checks=%0d", miscompares, checks);
    if (miscompares == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (pix_rd === 1'b1) pix_data <= px(pix_req);
    if (frame_unique === 1'b1) uniq++;
  end
  always @(u_tvsf_host.got) begin
    if (exp_q.size() == 0) begin
      miscompares++;
      $display("ERROR %0t: unexpected byte", $time);
    end else begin
      exp_b = exp_q.pop_front();
      `CHK(u_tvsf_host.rx_byte, exp_b)
    end
  end
  initial begin
    #420000;
    miscompares++;
    finish_test();
  end
  initial begin
    miscompares = 0;
    checks = 0;
    uniq = 0;
    sys_rst = 1'b1;
    ce = 1'b1;
    cfg = '0;
    pix_data = 24'h0;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (100) @(posedge clk_sys);
    expect_pkt(0, 0, 164);
    expect_pkt(0, 0, 164);
    `CHK(link_synced, 1'b1)
    // Settings are taken when the next packet is prepared, a few clocks after the last bit.
    expect_pkt(1, 0, 164);
    @(posedge clk_sys) cfg.automatic_gain_control <= 1'b1;
    expect_pkt(2, 1, 164);
    `CHK(link_lost, 1'b1)
    expect_pkt(0, 0, 164);
    @(posedge clk_sys) cfg.three_byte_colour_format <= 1'b1;
    u_tvsf_host.idle(8400);
    `CHK({link_synced, link_lost}, 2'b00)
    expect_pkt(0, 0, 244);
    expect_pkt(0, 0, 244);
    expect_pkt(3, 0, 244);
    `CHK(frame_count, 32'(3 * (uniq - 1)))
    finish_test();
  end
endmodule
`default_nettype wire
